// ### bench/dtsr_far_side.sv
// Far-side model: outside circuitry and peer cards driving the timing pins.
// Assumes the bench calls its tasks from one process; pins move at falling edges.
`timescale 1ns/1ps
module dtsr_far_side
  import dtsr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [1:0]          clk_on,
  output logic      [NUM_PINS-1:0] pins
);
  int unsigned ph = 0;

  initial pins = '0;

  // Clock lines toggle every two cycles (10 MHz) and stand still when off
  always @(negedge clk) begin
    ph <= ph + 1;
    pins[PIN_EXT_CLK]  <= clk_on[0] & ph[1];
    pins[PIN_SYNC_CLK] <= clk_on[1] & ph[1];
  end

  // Pin to lvl for hi cycles (at least two), then back for lo cycles
  task automatic pulse(input int idx, input logic lvl, input int hi, input int lo);
    @(negedge clk);
    pins[idx] = lvl;
    repeat (hi < 2 ? 2 : hi) @(negedge clk);
    pins[idx] = ~lvl;
    repeat (lo) @(negedge clk);
  endtask

  // Park a pin at a level
  task automatic setl(input int idx, input logic lvl);
    @(negedge clk);
    pins[idx] = lvl;
    repeat (3) @(negedge clk);
  endtask
endmodule

// ### bench/test_daq_timing_source_router.sv
// Self-checking bench for the timing source router with a far-side pin model.
// Assumes dtsr_pkg, the design files and dtsr_far_side are compiled first.
`timescale 1ns/1ps
module test_daq_timing_source_router
  import dtsr_pkg::*;
;
  localparam int NCH = 4;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic [1:0]        tb_sel, acq_sel, out_sel, scan_sel, conv_sel, upd_sel, clk_on;
  logic              acq_fall, out_fall, acq_sw, out_sw, ana, acq_stop, out_stop;
  logic [15:0]       scan_div, conv_div, upd_div;
  logic [NUM_PINS-1:0] pins;
  logic              tick, acq_trg, out_trg, scan_b, conv, upd, acq_run, out_run;
  int                cn_tick, cn_acq, cn_out, cn_scan, cn_conv, cn_upd, n;
  int                failures = 0;
  int                n_compared = 0;
  logic [31:0]       seed = 32'h49;

  // Clock, 25 ns period
  always #12.5 clk = ~clk;

  dtsr_router #(.DIV_W(16), .NUM_CH(NCH)) i_dtsr_router (
    .CLK(clk), .NRST(nrst), .TB_SEL(tb_sel), .ACQ_TRIG_SEL(acq_sel), .OUT_TRIG_SEL(out_sel),
    .ACQ_EDGE_FALL(acq_fall), .OUT_EDGE_FALL(out_fall), .SCAN_SEL(scan_sel),
    .CONV_SEL(conv_sel), .UPD_SEL(upd_sel), .SCAN_DIV(scan_div), .CONV_DIV(conv_div),
    .UPD_DIV(upd_div), .ACQ_SW_TRIG(acq_sw), .OUT_SW_TRIG(out_sw), .ANALOG_TRIG(ana),
    .ACQ_STOP(acq_stop), .OUT_STOP(out_stop),
    .EXTERNAL_CLOCK_INPUT(pins[PIN_EXT_CLK]), .SYNC_BUS_CLOCK_LINE(pins[PIN_SYNC_CLK]),
    .ACQ_EXTERNAL_EDGE_TRIGGER(pins[PIN_ACQ_EXT]),
    .WAVEFORM_EXTERNAL_EDGE_TRIGGER(pins[PIN_WAVE_EXT]),
    .AUX_INPUT_ZERO(pins[PIN_AUX0]), .AUX_INPUT_ONE(pins[PIN_AUX1]),
    .SYNC_BUS_ACQ_TRIGGER_LINE(pins[PIN_SYNC_ACQ]),
    .SYNC_BUS_OUT_TRIGGER_LINE(pins[PIN_SYNC_OUT]),
    .SYNC_BUS_SCAN_BEGIN_LINE(pins[PIN_SYNC_SCAN]),
    .SYNC_BUS_CONVERSION_LINE(pins[PIN_SYNC_CONV]), .SYNC_BUS_UPDATE_LINE(pins[PIN_SYNC_UPD]),
    .TB_TICK(tick), .ACQ_TRIGGER(acq_trg), .OUTPUT_TRIGGER(out_trg), .SCAN_BEGIN(scan_b),
    .SAMPLE_CONVERSION_STROBE(conv), .OUTPUT_UPDATE_STROBE(upd),
    .ACQ_RUNNING(acq_run), .OUT_RUNNING(out_run)
  );

  dtsr_far_side i_dtsr_far_side (.clk(clk), .clk_on(clk_on), .pins(pins));

  // Pulse counters on every output but the two run flags
  always @(posedge clk) begin
    if (tick === 1'b1) cn_tick++;
    if (acq_trg === 1'b1) cn_acq++;
    if (out_trg === 1'b1) cn_out++;
    if (scan_b === 1'b1) cn_scan++;
    if (conv === 1'b1) cn_conv++;
    if (upd === 1'b1) cn_upd++;
  end

  // Xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Timebase steps expected in a span of cycles
  function automatic int exp_ticks(input int sel, input int cyc);
    return (sel == 1 || sel == 2) ? cyc / 4 : cyc;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %0d expected %0d", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic clr();
    {cn_tick, cn_acq, cn_out, cn_scan, cn_conv, cn_upd} = '0;
  endtask

  task automatic wt(input int c);
    repeat (c) @(negedge clk);
  endtask

  // One-cycle same-clock pulse
  task automatic strobe(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic stop_all();
    strobe(acq_stop);
    strobe(out_stop);
  endtask

  // Fire trigger source s of one path
  task automatic fire(input bit acq, input int s, input logic f);
    case (s)
      0: i_dtsr_far_side.pulse(acq ? PIN_ACQ_EXT : PIN_WAVE_EXT, ~f, 2, 3);
      1: strobe(ana);
      2: if (acq) strobe(acq_sw); else strobe(out_sw);
      default: i_dtsr_far_side.pulse(acq ? PIN_SYNC_ACQ : PIN_SYNC_OUT, 1'b1, 2, 3);
    endcase
  endtask

  // Reset with aux activity; everything stays quiet
  task automatic do_reset();
    @(negedge clk);
    nrst = 1'b0;
    clr();
    i_dtsr_far_side.pulse(PIN_AUX0, 1'b1, 2, 2);
    wt(7);
    check(cn_conv + cn_acq + cn_out + cn_scan + cn_upd + cn_tick, 0, "reset quiet");
    check({acq_run, out_run}, 0, "run in reset");
    nrst = 1'b1;
    wt(3);
  endtask

  // Every timebase choice, value 3 included
  task automatic t_timebase();
    int e, tol;
    for (int k = 0; k < 4; k++) begin
      tb_sel = 2'(k);
      clk_on = (k == 1) ? 2'h1 : (k == 2) ? 2'h2 : 2'h0;
      wt(10);
      clr();
      wt(80);
      e = exp_ticks(k, 80);
      tol = (k % 3 != 0) ? 1 : 0;
      check(cn_tick >= e - tol && cn_tick <= e + tol, 1, "tick rate");
    end
    {clk_on, tb_sel} = '0;
    $display("done: timebase");
  endtask

  // Every trigger source of both paths, random edge, refusals
  task automatic t_trig();
    int p;
    logic f;
    for (int s = 0; s < 4; s++) begin
      for (int a = 0; a < 2; a++) begin
        f = 1'(rnd() & 32'h1);
        p = a ? PIN_ACQ_EXT : PIN_WAVE_EXT;
        if (a) {acq_sel, acq_fall} = {2'(s), f}; else {out_sel, out_fall} = {2'(s), f};
        if (s == 0) i_dtsr_far_side.setl(p, f);
        clr();
        fire(a, (s + 1) % 4, f);
        wt(8);
        check(a ? cn_acq : cn_out, 0, "wrong source");
        fire(a, s, f);
        wt(8);
        check(a ? cn_acq : cn_out, 1, "trigger");
        check(a ? acq_run : out_run, 1, "running");
        fire(a, s, f);
        wt(8);
        check(a ? cn_acq : cn_out, 1, "busy trigger");
        if (s == 0) i_dtsr_far_side.setl(p, 1'b0);
        stop_all();
      end
    end
    $display("done: triggers");
  endtask

  // Aux and sync conversion and update strobes, random counts and widths
  task automatic t_strobe();
    int pk[4] = '{PIN_AUX0, PIN_SYNC_CONV, PIN_AUX1, PIN_SYNC_UPD};
    for (int k = 0; k < 4; k++) begin
      conv_sel = (k < 2) ? 2'(k + 1) : 2'h3;
      upd_sel = (k < 2) ? 2'h3 : 2'(k - 1);
      {scan_sel, acq_sel} = 4'h6;
      wt(3);
      clr();
      strobe(acq_sw);
      n = 1 + rnd() % 6;
      repeat (n) i_dtsr_far_side.pulse(pk[k], 1'b1, 2 + rnd() % 3, 2 + rnd() % 3);
      wt(8);
      check(k < 2 ? cn_conv : cn_upd, n, "strobe count");
      if (k == 0) check(cn_scan + cn_acq, 0, "aux zero conversion only");
      stop_all();
    end
    {conv_sel, upd_sel, scan_sel} = '0;
    $display("done: strobes");
  endtask

  // Scan from counter, aux zero and sync bus, with conversions per scan
  task automatic t_scan();
    for (int k = 0; k < 3; k++) begin
      scan_sel = 2'(k);
      conv_div = (k == 0) ? 16'h0002 : 16'h0001;
      wt(12);
      strobe(acq_sw);
      clr();
      if (k == 0) begin
        wt(200);
        check(cn_scan >= 9 && cn_scan <= 11, 1, "scan period");
        check(cn_conv >= NCH * (cn_scan - 1) && cn_conv <= NCH * cn_scan, 1, "conv");
      end else begin
        n = 1 + rnd() % 5;
        repeat (n) i_dtsr_far_side.pulse(k == 1 ? PIN_AUX0 : PIN_SYNC_SCAN, 1'b1, 3, 12);
        wt(10);
        check(cn_scan, n, "scan count");
        check(cn_conv, NCH * n, "conv per scan");
      end
      stop_all();
    end
    scan_sel = 2'h0;
    $display("done: scans");
  endtask

  // One outside timebase paces both acquisition and output counters
  task automatic t_shared();
    {tb_sel, clk_on} = 4'h5;
    out_sel = 2'h2;
    {scan_div, upd_div} = {16'h000A, 16'h0005};
    strobe(acq_sw);
    strobe(out_sw);
    clr();
    wt(200);
    n = exp_ticks(1, 200);
    check(cn_scan >= n / 10 - 1 && cn_scan <= n / 10 + 1, 1, "scan on ext");
    check(cn_upd >= n / 5 - 1 && cn_upd <= n / 5 + 1, 1, "upd on ext");
    stop_all();
    {tb_sel, clk_on} = '0;
    strobe(out_sw);
    do_reset();
    check(out_run, 0, "run after reset");
    $display("done: shared timebase and reset");
  endtask

  initial begin
    {tb_sel, out_sel, scan_sel, conv_sel, upd_sel, clk_on} = '0;
    {acq_fall, out_fall, acq_sw, out_sw, ana, acq_stop, out_stop} = '0;
    acq_sel = 2'h2;
    {scan_div, conv_div, upd_div} = {16'h0014, 16'h0002, 16'h0005};
    do_reset();
    t_timebase();
    t_trig();
    t_strobe();
    t_scan();
    t_shared();
    conclude();
  end

  // Cut a hang short, far beyond the expected run length
  initial begin
    #(20000 * 25);
    failures++;
    conclude();
  end
endmodule

// ### hdl/dtsr_edge.sv
// Two-flop synchroniser with selectable edge detect, one-cycle pulse out.
// Assumes the pin is asynchronous to clk; pulses shorter than a clock
// period may be missed.
`timescale 1ns/1ps
module dtsr_edge
  import dtsr_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pin,
  input  wire logic fall_sel,
  output logic      pulse
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic pulse;
  } dtsr_edge_st_t;

  dtsr_edge_st_t st_ff;
  dtsr_edge_st_t nxt_st;

  // Synchronise, then compare settled samples only
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.meta  = pin;
    nxt_st.sync  = st_ff.meta;
    nxt_st.prev  = st_ff.sync;
    nxt_st.pulse = fall_sel ? (~st_ff.sync & st_ff.prev)   // [R07] [R17]
                            : (st_ff.sync & ~st_ff.prev);  // [R17]
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse = st_ff.pulse;

  // One pulse per selected edge of the settled input
  chk_edge_rise_fall: assert property (@(posedge clk) disable iff (!nrst) // [R07] [R17]
    pulse |-> ($past(fall_sel) ? !$past(st_ff.sync, 1) && $past(st_ff.prev, 1)
                               : $past(st_ff.sync, 1) && !$past(st_ff.prev, 1)))
    else $error("edge pulse without matching edge");
  chk_edge_single: assert property (@(posedge clk) disable iff (!nrst) // [R17]
    pulse |=> !pulse)
    else $error("edge pulse longer than one cycle");

endmodule

// ### hdl/dtsr_ivl.sv
// Interval counter stepped by the timebase enable; hit pulse every div steps.
// Assumes en is a one-cycle enable on the same clock; div of zero acts as one.
`timescale 1ns/1ps
module dtsr_ivl
  import dtsr_pkg::*;
#(
  parameter int W = 16
)
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         en,
  input  wire logic         clr,
  input  wire logic [W-1:0] div,
  output logic              hit
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         hit;
  } dtsr_ivl_st_t;

  dtsr_ivl_st_t st_ff;
  dtsr_ivl_st_t nxt_st;
  logic [W-1:0] last;

  // Count timebase steps, wrap and pulse at the last one
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.hit = 1'b0;
    last       = (div == '0) ? '0 : div - W'(1);
    if (clr) begin
      nxt_st.cnt = '0;
    end else if (en) begin  // [R04]
      if (st_ff.cnt >= last) begin
        nxt_st.cnt = '0;
        nxt_st.hit = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hit = st_ff.hit;

  chk_ivl_on_step: assert property (@(posedge clk) disable iff (!nrst) // [R04]
    hit |-> $past(en) && !$past(clr))
    else $error("interval hit without a timebase step");

endmodule

// ### hdl/dtsr_pkg.sv
// Constants and types shared by the timing source router files.
// Assumes a single 40 MHz system clock drives every module that imports it.
package dtsr_pkg;

  // System clock
  localparam int CLK_HZ             = 40_000_000;
  localparam int CLK_PERIOD_NS      = 1_000_000_000 / CLK_HZ;

  // External timebase limits kept by the far side
  localparam int EXT_CLK_MIN_HZ     = 1_000_000;
  localparam int EXT_CLK_MAX_HZ     = 40_000_000;

  // Least aux strobe width kept by the far side, and its cycle count
  localparam int AUX_MIN_PULSE_NS   = 20;
  localparam int AUX_MIN_PULSE_CYC  =
    ((AUX_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((AUX_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Scan-begin from aux zero is held longer than this many timebase periods
  localparam int SCAN_MIN_TB_PERIODS = 2;

  // Positions of the synchronised pins in the pin vector
  localparam int PIN_EXT_CLK   = 0;
  localparam int PIN_SYNC_CLK  = 1;
  localparam int PIN_ACQ_EXT   = 2;
  localparam int PIN_WAVE_EXT  = 3;
  localparam int PIN_AUX0      = 4;
  localparam int PIN_AUX1      = 5;
  localparam int PIN_SYNC_ACQ  = 6;
  localparam int PIN_SYNC_OUT  = 7;
  localparam int PIN_SYNC_SCAN = 8;
  localparam int PIN_SYNC_CONV = 9;
  localparam int PIN_SYNC_UPD  = 10;
  localparam int NUM_PINS      = 11;

  // Source choices
  typedef enum logic [1:0] {TB_INTERNAL, TB_EXTERNAL, TB_SYNC_BUS} dtsr_tb_src_t;
  typedef enum logic [1:0] {TRG_EXT_EDGE, TRG_ANALOG, TRG_SOFTWARE, TRG_SYNC_BUS} dtsr_trig_src_t;
  typedef enum logic [1:0] {STB_INTERNAL, STB_AUX, STB_SYNC_BUS} dtsr_stb_src_t;

  // Values after reset: every source internal
  localparam dtsr_tb_src_t   RST_TB_SEL   = TB_INTERNAL;
  localparam dtsr_trig_src_t RST_TRIG_SEL = TRG_SOFTWARE;
  localparam dtsr_stb_src_t  RST_STB_SEL  = STB_INTERNAL;
  localparam logic           RST_FALL_SEL = 1'b0;

endpackage

// ### hdl/dtsr_router.sv
// Timing source router: picks timebase, triggers, scan, conversion, update.
// Assumes config ports come from same-clock logic; all pins are asynchronous.
//
// Functional notes
// R01 - Master count clock from internal 40 MHz, external clock input or sync bus.
// R02 - Far side keeps the external clock between 1 MHz and 40 MHz.
// R03 - One timebase choice drives both acquisition and output paths.
// R04 - Interval counters step on the selected timebase, external included.
// R05 - Acquisition trigger from external edge, analog, software or sync bus.
// R06 - Output trigger from waveform edge, analog, software or sync bus.
// R07 - Two dedicated edge trigger inputs, each rising or falling selectable.
// R08 - Scan-begin from interval counter, aux zero or sync bus, timebase aligned.
// R09 - Far side holds aux zero scan pulses over two timebase periods.
// R10 - Conversion strobe from counter, aux zero or sync bus; one per rise.
// R11 - Aux zero conversions disable scan counter and internal scan-begin.
// R12 - Aux zero conversions make trigger source and mode ineffective.
// R13 - Update strobe from counter, aux one or sync bus; one per rise.
// R14 - Far side makes aux strobe pulses at least 20 ns wide.
// R15 - Each aux input serves one function; aux zero conversion wins over scan.
// R16 - Reset returns every routed signal to its internal source.
// R17 - External inputs synchronised, edge detected, one-cycle pulse per edge.
`timescale 1ns/1ps
module dtsr_router
  import dtsr_pkg::*;
#(
  parameter int DIV_W  = 16,
  parameter int NUM_CH = 4
)
(
  input  wire logic             CLK,
  input  wire logic             NRST,
  input  wire logic [1:0]       TB_SEL,
  input  wire logic [1:0]       ACQ_TRIG_SEL,
  input  wire logic [1:0]       OUT_TRIG_SEL,
  input  wire logic             ACQ_EDGE_FALL,
  input  wire logic             OUT_EDGE_FALL,
  input  wire logic [1:0]       SCAN_SEL,
  input  wire logic [1:0]       CONV_SEL,
  input  wire logic [1:0]       UPD_SEL,
  input  wire logic [DIV_W-1:0] SCAN_DIV,
  input  wire logic [DIV_W-1:0] CONV_DIV,
  input  wire logic [DIV_W-1:0] UPD_DIV,
  input  wire logic             ACQ_SW_TRIG,
  input  wire logic             OUT_SW_TRIG,
  input  wire logic             ANALOG_TRIG,
  input  wire logic             ACQ_STOP,
  input  wire logic             OUT_STOP,
  input  wire logic             EXTERNAL_CLOCK_INPUT,
  input  wire logic             SYNC_BUS_CLOCK_LINE,
  input  wire logic             ACQ_EXTERNAL_EDGE_TRIGGER,
  input  wire logic             WAVEFORM_EXTERNAL_EDGE_TRIGGER,
  input  wire logic             AUX_INPUT_ZERO,
  input  wire logic             AUX_INPUT_ONE,
  input  wire logic             SYNC_BUS_ACQ_TRIGGER_LINE,
  input  wire logic             SYNC_BUS_OUT_TRIGGER_LINE,
  input  wire logic             SYNC_BUS_SCAN_BEGIN_LINE,
  input  wire logic             SYNC_BUS_CONVERSION_LINE,
  input  wire logic             SYNC_BUS_UPDATE_LINE,
  output logic                  TB_TICK,
  output logic                  ACQ_TRIGGER,
  output logic                  OUTPUT_TRIGGER,
  output logic                  SCAN_BEGIN,
  output logic                  SAMPLE_CONVERSION_STROBE,
  output logic                  OUTPUT_UPDATE_STROBE,
  output logic                  ACQ_RUNNING,
  output logic                  OUT_RUNNING
);

  localparam int CH_W = $clog2(NUM_CH + 1);

  typedef struct packed {
    dtsr_tb_src_t   tb_sel;
    dtsr_trig_src_t acq_sel;
    dtsr_trig_src_t out_sel;
    dtsr_stb_src_t  scan_sel;
    dtsr_stb_src_t  conv_sel;
    dtsr_stb_src_t  upd_sel;
    logic           acq_fall;
    logic           out_fall;
    logic           acq_run;
    logic           out_run;
    logic           scan_pend;
    logic [CH_W-1:0] conv_left;
    logic           tick;
    logic           acq_trig;
    logic           out_trig;
    logic           scan_begin;
    logic           conv_stb;
    logic           upd_stb;
  } dtsr_top_st_t;

  dtsr_top_st_t        st_ff;
  dtsr_top_st_t        nxt_st;
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] fall;
  logic [NUM_PINS-1:0] edge_p;
  logic                tick_c;
  logic                conv_aux;
  logic                scan_aux;
  logic                acq_src_p;
  logic                out_src_p;
  logic                acq_fire;
  logic                out_fire;
  logic                ext_scan_edge;
  logic                scan_rel;
  logic                scan_now;
  logic                scan_hit;
  logic                conv_hit;
  logic                upd_hit;
  logic                scan_en;
  logic                conv_en;
  logic                upd_en;

  // Gather the pins; only the two dedicated triggers take a falling edge
  assign pins = {SYNC_BUS_UPDATE_LINE, SYNC_BUS_CONVERSION_LINE,
                 SYNC_BUS_SCAN_BEGIN_LINE, SYNC_BUS_OUT_TRIGGER_LINE,
                 SYNC_BUS_ACQ_TRIGGER_LINE, AUX_INPUT_ONE, AUX_INPUT_ZERO,
                 WAVEFORM_EXTERNAL_EDGE_TRIGGER, ACQ_EXTERNAL_EDGE_TRIGGER,
                 SYNC_BUS_CLOCK_LINE, EXTERNAL_CLOCK_INPUT};
  always_comb begin
    fall               = '0;
    fall[PIN_ACQ_EXT]  = st_ff.acq_fall;  // [R07]
    fall[PIN_WAVE_EXT] = st_ff.out_fall;  // [R07]
  end

  // Synchroniser and edge detect per pin
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    dtsr_edge u_edge (
      .clk      (CLK),
      .nrst     (NRST),
      .pin      (pins[i]),
      .fall_sel (fall[i]),
      .pulse    (edge_p[i])
    );
  end

  // Interval counters all stepped by the one timebase enable
  dtsr_ivl #(.W(DIV_W)) u_scan_ivl (
    .clk  (CLK),
    .nrst (NRST),
    .en   (scan_en),
    .clr  (1'b0),
    .div  (SCAN_DIV),
    .hit  (scan_hit)
  );
  dtsr_ivl #(.W(DIV_W)) u_conv_ivl (
    .clk  (CLK),
    .nrst (NRST),
    .en   (conv_en),
    .clr  (scan_now),
    .div  (CONV_DIV),
    .hit  (conv_hit)
  );
  dtsr_ivl #(.W(DIV_W)) u_upd_ivl (
    .clk  (CLK),
    .nrst (NRST),
    .en   (upd_en),
    .clr  (1'b0),
    .div  (UPD_DIV),
    .hit  (upd_hit)
  );

  // Timebase enable: every cycle, or one per rising edge of the chosen line
  always_comb begin
    unique case (st_ff.tb_sel)
      TB_INTERNAL: tick_c = 1'b1;                  // [R01]
      TB_EXTERNAL: tick_c = edge_p[PIN_EXT_CLK];   // [R01] [R04]
      TB_SYNC_BUS: tick_c = edge_p[PIN_SYNC_CLK];  // [R01]
      default:     tick_c = 1'b1;
    endcase
  end

  // Aux zero ownership: conversion use excludes scan use
  assign conv_aux = (st_ff.conv_sel == STB_AUX);
  assign scan_aux = (st_ff.scan_sel == STB_AUX) && !conv_aux;  // [R15]

  // Trigger source selection
  always_comb begin
    unique case (st_ff.acq_sel)
      TRG_EXT_EDGE: acq_src_p = edge_p[PIN_ACQ_EXT];  // [R05]
      TRG_ANALOG:   acq_src_p = ANALOG_TRIG;          // [R05]
      TRG_SOFTWARE: acq_src_p = ACQ_SW_TRIG;          // [R05]
      TRG_SYNC_BUS: acq_src_p = edge_p[PIN_SYNC_ACQ]; // [R05]
    endcase
    unique case (st_ff.out_sel)
      TRG_EXT_EDGE: out_src_p = edge_p[PIN_WAVE_EXT]; // [R06]
      TRG_ANALOG:   out_src_p = ANALOG_TRIG;          // [R06]
      TRG_SOFTWARE: out_src_p = OUT_SW_TRIG;          // [R06]
      TRG_SYNC_BUS: out_src_p = edge_p[PIN_SYNC_OUT]; // [R06]
    endcase
  end
  assign acq_fire = acq_src_p && !conv_aux && !st_ff.acq_run;  // [R12]
  assign out_fire = out_src_p && !st_ff.out_run;

  // Scan-begin: counter hits, or external edges held until the next step
  assign scan_en       = tick_c && st_ff.acq_run && !conv_aux           // [R11]
                         && (st_ff.scan_sel == STB_INTERNAL);
  assign ext_scan_edge = st_ff.acq_run && !conv_aux
                         && ((scan_aux && edge_p[PIN_AUX0])             // [R08]
                         || ((st_ff.scan_sel == STB_SYNC_BUS) && edge_p[PIN_SYNC_SCAN]));
  // Release on the registered step so both scan paths land two cycles after it
  assign scan_rel      = st_ff.scan_pend && st_ff.tick;                 // [R08]
  assign scan_now      = (scan_hit && !conv_aux) || scan_rel;           // [R11]

  // Conversion and update counters run only while selected
  assign conv_en = tick_c && (st_ff.conv_left != '0) && (st_ff.conv_sel == STB_INTERNAL);
  assign upd_en  = tick_c && st_ff.out_run && (st_ff.upd_sel == STB_INTERNAL);  // [R03]

  // Next state
  always_comb begin
    nxt_st          = st_ff;
    // Selections sampled from software each cycle
    nxt_st.tb_sel   = dtsr_tb_src_t'(TB_SEL);
    nxt_st.acq_sel  = dtsr_trig_src_t'(ACQ_TRIG_SEL);
    nxt_st.out_sel  = dtsr_trig_src_t'(OUT_TRIG_SEL);
    nxt_st.scan_sel = dtsr_stb_src_t'(SCAN_SEL);
    nxt_st.conv_sel = dtsr_stb_src_t'(CONV_SEL);
    nxt_st.upd_sel  = dtsr_stb_src_t'(UPD_SEL);
    nxt_st.acq_fall = ACQ_EDGE_FALL;
    nxt_st.out_fall = OUT_EDGE_FALL;
    // Run flags: a trigger arms, a stop disarms
    nxt_st.acq_run  = (st_ff.acq_run && !ACQ_STOP) || acq_fire;
    nxt_st.out_run  = (st_ff.out_run && !OUT_STOP) || out_fire;
    // Pending external scan; a new edge wins over the release
    nxt_st.scan_pend = (st_ff.scan_pend && !st_ff.tick) || ext_scan_edge;
    // Conversions left in the current scan
    if (scan_now) begin
      nxt_st.conv_left = CH_W'(NUM_CH);  // [R08]
    end else if (conv_hit && (st_ff.conv_left != '0)) begin
      nxt_st.conv_left = st_ff.conv_left - CH_W'(1);
    end
    // Registered strobes
    nxt_st.tick       = tick_c;
    nxt_st.acq_trig   = acq_fire;
    nxt_st.out_trig   = out_fire;
    nxt_st.scan_begin = scan_now;
    unique case (st_ff.conv_sel)
      STB_INTERNAL: nxt_st.conv_stb = conv_hit && (st_ff.conv_left != '0);  // [R08]
      STB_AUX:      nxt_st.conv_stb = edge_p[PIN_AUX0];       // [R10]
      STB_SYNC_BUS: nxt_st.conv_stb = edge_p[PIN_SYNC_CONV];  // [R10]
      default:      nxt_st.conv_stb = 1'b0;
    endcase
    unique case (st_ff.upd_sel)
      STB_INTERNAL: nxt_st.upd_stb = upd_hit;
      STB_AUX:      nxt_st.upd_stb = edge_p[PIN_AUX1];        // [R13]
      STB_SYNC_BUS: nxt_st.upd_stb = edge_p[PIN_SYNC_UPD];    // [R13]
      default:      nxt_st.upd_stb = 1'b0;
    endcase
  end

  // State register; reset puts every source back to internal
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_ff          <= '0;
      st_ff.tb_sel   <= RST_TB_SEL;    // [R16]
      st_ff.acq_sel  <= RST_TRIG_SEL;  // [R16]
      st_ff.out_sel  <= RST_TRIG_SEL;  // [R16]
      st_ff.scan_sel <= RST_STB_SEL;   // [R16]
      st_ff.conv_sel <= RST_STB_SEL;   // [R16]
      st_ff.upd_sel  <= RST_STB_SEL;   // [R16]
      st_ff.acq_fall <= RST_FALL_SEL;
      st_ff.out_fall <= RST_FALL_SEL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign TB_TICK                  = st_ff.tick;
  assign ACQ_TRIGGER              = st_ff.acq_trig;
  assign OUTPUT_TRIGGER           = st_ff.out_trig;
  assign SCAN_BEGIN               = st_ff.scan_begin;
  assign SAMPLE_CONVERSION_STROBE = st_ff.conv_stb;
  assign OUTPUT_UPDATE_STROBE     = st_ff.upd_stb;
  assign ACQ_RUNNING              = st_ff.acq_run;
  assign OUT_RUNNING              = st_ff.out_run;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  chk_tick_internal: assert property ( // [R01]
    st_ff.tb_sel == TB_INTERNAL |=> TB_TICK)
    else $error("internal timebase missed a step");
  chk_tb_shared: assert property ( // [R03]
    (SAMPLE_CONVERSION_STROBE && $past(st_ff.conv_sel, 1) == STB_INTERNAL)
    || (OUTPUT_UPDATE_STROBE && $past(st_ff.upd_sel, 1) == STB_INTERNAL)
    |-> $past(tick_c, 2))
    else $error("internal strobe not on a timebase step");
  chk_trig_ignored: assert property ( // [R12]
    conv_aux |=> !ACQ_TRIGGER)
    else $error("acquisition trigger while aux conversions");
  chk_scan_aligned: assert property ( // [R08]
    SCAN_BEGIN |-> $past(tick_c, 2))
    else $error("scan begin not on a timebase step");
  chk_aux0_conv: assert property ( // [R10]
    conv_aux && edge_p[PIN_AUX0] |=> SAMPLE_CONVERSION_STROBE ##1 !SAMPLE_CONVERSION_STROBE)
    else $error("aux zero edge gave no single conversion");
  chk_scan_blocked: assert property ( // [R11] [R15]
    conv_aux && $past(conv_aux) |=> !SCAN_BEGIN)
    else $error("scan begin while aux zero converts");
  chk_aux1_upd: assert property ( // [R13]
    st_ff.upd_sel == STB_AUX && edge_p[PIN_AUX1] |=> OUTPUT_UPDATE_STROBE)
    else $error("aux one edge gave no update");
  chk_out_sw_trig: assert property ( // [R06]
    st_ff.out_sel == TRG_SOFTWARE && OUT_SW_TRIG && !st_ff.out_run
    |=> OUTPUT_TRIGGER ##1 OUT_RUNNING)
    else $error("software output trigger lost");
  chk_ext_scan_held: assert property ( // [R08]
    ext_scan_edge |=> st_ff.scan_pend)
    else $error("external scan edge dropped");

  cov_internal_scan: cover property (
    st_ff.scan_sel == STB_INTERNAL && SCAN_BEGIN ##[1:40] SAMPLE_CONVERSION_STROBE);
  cov_aux_conv:      cover property (conv_aux && SAMPLE_CONVERSION_STROBE);
  cov_ext_tb_upd:    cover property (st_ff.tb_sel == TB_EXTERNAL && OUTPUT_UPDATE_STROBE);
  cov_sync_upd:      cover property (st_ff.upd_sel == STB_SYNC_BUS && OUTPUT_UPDATE_STROBE);

endmodule
